// *** verilog/cmpc_pkg.sv ***
// Package for the dual comparator control block: register offsets, field positions, reset values.
// Assumes a byte-wide register port with a 4-bit word address.
package cmpc_pkg;
  localparam int          ADDR_W       = 4;
  localparam int          DATA_W       = 8;
  localparam int          NUM_CMP      = 2;
  // Register offsets
  localparam logic [3:0]  OFS_CTL_ONE  = 4'h0;
  localparam logic [3:0]  OFS_CTL_TWO  = 4'h1;
  localparam logic [3:0]  OFS_AUX      = 4'h2;
  localparam logic [3:0]  OFS_IRQ      = 4'h3;
  // Control register fields
  localparam int          CTL_ON       = 7;
  localparam int          CTL_OUT      = 6;
  localparam int          CTL_OE       = 5;
  localparam int          CTL_POL      = 4;
  localparam int          CTL_SP       = 3;
  localparam int          CTL_REF      = 2;
  localparam int          CTL_CH_HI    = 1;
  localparam int          CTL_CH_LO    = 0;
  localparam logic [7:0]  CTL_RST      = 8'h08;
  // Aux register fields
  localparam int          AUX_MIR_ONE  = 7;
  localparam int          AUX_MIR_TWO  = 6;
  localparam logic [7:0]  AUX_WR_MASK  = 8'h3f;
  localparam logic [7:0]  AUX_RST      = 8'h00;
  // Interrupt register fields
  localparam int          IRQ_FLAG_LO  = 0;
  localparam int          IRQ_IE_LO    = 2;
  localparam int          IRQ_PERIPHERAL_IRQ_ENABLE     = 4;
  localparam int          IRQ_GIE      = 5;
  localparam logic [7:0]  IRQ_WR_MASK  = 8'h3f;
  localparam logic [7:0]  IRQ_RST      = 8'h00;
  // Instruction cycle of four clocks, first phase strobe at phase zero
  localparam int          PHASES       = 4;
  localparam logic [1:0]  PHASE_FIRST  = 2'h0;
  localparam logic [1:0]  PHASE_LAST   = 2'h3;
endpackage : cmpc_pkg

// *** verilog/cmpc_top.sv ***
// Dual comparator digital control: control registers, change detect, interrupt flags, shared pin.
// Assumes the analog cores deliver their raw results synchronous to clk.
`timescale 1ns/10ps

// Overview of operation
// - Speed select resets to one, normal speed
// - First latch captures output on control read
// - Second latch samples each first phase; XOR
// - Mismatch holds until read or output returns
// - Any control write clears mismatch
// - Flag sets on mismatch rising edge
// - After clear, interrupt only on later change
// - Flag cleared by writing zero; one sets
// - Request needs all three enables; flag regardless
// - Disabled comparator output follows polarity bit
// - Access clears latches; new config at write
// - Change during read may miss flag
// - Enable bit turns comparator on, runs asleep
// - Output change wakes device with enables
// - Reset returns all control registers off
// - Output bit is comparison, polarity inverts
// - Reference select picks internal reference or pin
// - Channel select routes ground or three pins
// - Pin driven with oe, enable, direction low
// - Second output enable wins the shared pin
// - Internal output relatched each instruction cycle
// - Mirror bits read leave latches untouched
module cmpc_top (
  input  wire logic                           clk,
  input  wire logic                           rstn,
  input  wire logic [cmpc_pkg::ADDR_W-1:0]    addr,
  input  wire logic [cmpc_pkg::DATA_W-1:0]    wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output logic      [cmpc_pkg::DATA_W-1:0]    rdata,
  input  wire logic [cmpc_pkg::NUM_CMP-1:0]   cmp_raw,
  input  wire logic                           sleep_mode,
  input  wire logic                           pin_dir,
  input  wire logic                           port_latch,
  output logic [cmpc_pkg::NUM_CMP-1:0]        cmp_enable,
  output logic [cmpc_pkg::NUM_CMP-1:0]        speed_power_select,
  output logic [cmpc_pkg::NUM_CMP-1:0]        reference_select,
  output logic [2*cmpc_pkg::NUM_CMP-1:0]      inverting_channel_select,
  output logic [cmpc_pkg::NUM_CMP-1:0]        reference_source_select,
  output logic [cmpc_pkg::NUM_CMP-1:0]        hysteresis_enable,
  output logic                                shared_output_pin,
  output logic                                shared_output_pin_oe_n,
  output logic                                irq_req,
  output logic                                wake_req
);
  import cmpc_pkg::*;

  logic [1:0]          phase_r;
  logic                q1_r;
  logic [7:0]          ctl_r [NUM_CMP];
  logic [7:0]          aux_r;
  logic [7:0]          irq_r;
  logic [NUM_CMP-1:0]  out_now;
  logic [NUM_CMP-1:0]  latch_smp_r;
  logic [NUM_CMP-1:0]  latch_rd_r;
  logic [NUM_CMP-1:0]  mism;
  logic [NUM_CMP-1:0]  mism_d_r;
  logic [NUM_CMP-1:0]  ctl_acc;
  logic [NUM_CMP-1:0]  flag_set;
  logic [NUM_CMP-1:0]  flag_nxt;
  logic [NUM_CMP-1:0]  active_irq;
  logic [7:0]          rdata_nxt;

  // Instruction phase counter; first phase strobe held high during sleep while the counter keeps running
  always_ff @(posedge clk) begin
    if (!rstn) begin
      phase_r <= PHASE_FIRST;
      q1_r    <= 1'b0;
    end else begin
      phase_r <= (phase_r == PHASE_LAST) ? PHASE_FIRST : phase_r + 2'h1;
      q1_r    <= sleep_mode || (phase_r == PHASE_LAST);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMP; gi++) begin : g_cmp
      localparam logic [3:0] OFS = (gi == 0) ? OFS_CTL_ONE : OFS_CTL_TWO;

      // Disabled core reads as zero, polarity then sets the level
      assign out_now[gi]  = (ctl_r[gi][CTL_ON] & cmp_raw[gi]) ^ ctl_r[gi][CTL_POL];
      assign ctl_acc[gi]  = (rd || wr) && (addr == OFS);
      assign mism[gi]     = latch_rd_r[gi] ^ latch_smp_r[gi];
      assign flag_set[gi] = mism[gi] && !mism_d_r[gi];

      always_ff @(posedge clk) begin
        if (!rstn) begin
          ctl_r[gi] <= CTL_RST;
        end else if (wr && addr == OFS) begin
          ctl_r[gi] <= wdata;
        end
      end

      // Sampling latch, also the internal output seen by software
      always_ff @(posedge clk) begin
        if (!rstn) begin
          latch_smp_r[gi] <= 1'b0;
        end else if (q1_r) begin
          latch_smp_r[gi] <= out_now[gi];
        end
      end

      // Read latch takes the old level; config lands the same edge
      always_ff @(posedge clk) begin
        if (!rstn) begin
          latch_rd_r[gi] <= 1'b0;
        end else if (ctl_acc[gi]) begin
          latch_rd_r[gi] <= latch_smp_r[gi];
        end
      end

      always_ff @(posedge clk) begin
        if (!rstn) begin
          mism_d_r[gi] <= 1'b0;
        end else begin
          mism_d_r[gi] <= mism[gi];
        end
      end

      assign flag_nxt[gi] = ((wr && addr == OFS_IRQ) ? wdata[IRQ_FLAG_LO+gi] : irq_r[IRQ_FLAG_LO+gi])
                            | flag_set[gi];
      assign active_irq[gi] = irq_r[IRQ_FLAG_LO+gi] & irq_r[IRQ_IE_LO+gi];

      always_ff @(posedge clk) begin
        if (!rstn) begin
          cmp_enable[gi]                     <= 1'b0;
          speed_power_select[gi]             <= CTL_RST[CTL_SP];
          reference_select[gi]               <= 1'b0;
          inverting_channel_select[2*gi +: 2] <= 2'h0;
        end else begin
          cmp_enable[gi]                     <= ctl_r[gi][CTL_ON];
          speed_power_select[gi]             <= ctl_r[gi][CTL_SP];
          reference_select[gi]               <= ctl_r[gi][CTL_REF];
          inverting_channel_select[2*gi +: 2] <= ctl_r[gi][CTL_CH_HI:CTL_CH_LO];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rstn) begin
      aux_r <= AUX_RST;
    end else if (wr && addr == OFS_AUX) begin
      aux_r <= wdata & AUX_WR_MASK;
    end
  end

  // Flags: hardware set wins over a software clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_r <= IRQ_RST;
    end else begin
      irq_r[IRQ_FLAG_LO +: NUM_CMP] <= flag_nxt;
      if (wr && addr == OFS_IRQ) begin
        irq_r[7:IRQ_IE_LO] <= wdata[7:IRQ_IE_LO] & IRQ_WR_MASK[7:IRQ_IE_LO];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_req  <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      irq_req  <= (|active_irq) && irq_r[IRQ_PERIPHERAL_IRQ_ENABLE] && irq_r[IRQ_GIE];
      wake_req <= (|active_irq) && irq_r[IRQ_PERIPHERAL_IRQ_ENABLE];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      reference_source_select <= 2'h0;
      hysteresis_enable       <= 2'h0;
    end else begin
      reference_source_select <= {aux_r[4], aux_r[5]};
      hysteresis_enable       <= {aux_r[2], aux_r[3]};
    end
  end

  // Shared pin: second comparator has priority
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shared_output_pin      <= 1'b0;
      shared_output_pin_oe_n <= 1'b1;
    end else if (ctl_r[1][CTL_OE]) begin
      shared_output_pin      <= out_now[1];
      shared_output_pin_oe_n <= !(ctl_r[1][CTL_ON] && !pin_dir);
    end else if (ctl_r[0][CTL_OE]) begin
      shared_output_pin      <= out_now[0];
      shared_output_pin_oe_n <= !(ctl_r[0][CTL_ON] && !pin_dir);
    end else begin
      shared_output_pin      <= port_latch;
      shared_output_pin_oe_n <= 1'b1;
    end
  end

  // Read mux; unmapped reads zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (addr == OFS_CTL_ONE) begin
      rdata_nxt = ctl_r[0];
      rdata_nxt[CTL_OUT] = latch_smp_r[0];
    end else if (addr == OFS_CTL_TWO) begin
      rdata_nxt = ctl_r[1];
      rdata_nxt[CTL_OUT] = latch_smp_r[1];
    end else if (addr == OFS_AUX) begin
      rdata_nxt = aux_r;
      rdata_nxt[AUX_MIR_ONE] = latch_smp_r[0];
      rdata_nxt[AUX_MIR_TWO] = latch_smp_r[1];
    end else if (addr == OFS_IRQ) begin
      rdata_nxt = irq_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= 8'h00;
    end
  end

  property p_sp_reset;
    @(posedge clk) $rose(rstn) |-> speed_power_select == 2'h3;
  endproperty
  a_sp_reset: assert property (p_sp_reset) else $error("speed select not one after reset");

  property p_rd_capture;
    @(posedge clk) disable iff (!rstn) (rd && addr == OFS_CTL_ONE) |=> latch_rd_r[0] == $past(latch_smp_r[0]);
  endproperty
  a_rd_capture: assert property (p_rd_capture) else $error("read latch missed capture");

  property p_q1_period;
    @(posedge clk) disable iff (!rstn || sleep_mode) (q1_r && phase_r == PHASE_FIRST) |=> !q1_r [*3] ##1 q1_r;
  endproperty
  a_q1_period: assert property (p_q1_period) else $error("first phase strobe not every four clocks");

  property p_wr_clears;
    @(posedge clk) disable iff (!rstn) (wr && addr == OFS_CTL_TWO && !q1_r) |=> !mism[1];
  endproperty
  a_wr_clears: assert property (p_wr_clears) else $error("write did not clear mismatch");

  property p_edge_sets;
    @(posedge clk) disable iff (!rstn) (mism[0] && !mism_d_r[0]) |=> irq_r[IRQ_FLAG_LO];
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("mismatch edge did not set flag");

  property p_sw_set;
    @(posedge clk) disable iff (!rstn) (wr && addr == OFS_IRQ && wdata[IRQ_FLAG_LO+1]) |=> irq_r[IRQ_FLAG_LO+1];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("software set of flag lost");

  property p_irq_gate;
    @(posedge clk) disable iff (!rstn) !irq_r[IRQ_GIE] |=> !irq_req;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without global enable");

  property p_off_pol;
    @(posedge clk) disable iff (!rstn) !ctl_r[0][CTL_ON] |-> out_now[0] == ctl_r[0][CTL_POL];
  endproperty
  a_off_pol: assert property (p_off_pol) else $error("disabled output not polarity");

  property p_pin_prio;
    @(posedge clk) disable iff (!rstn) ctl_r[1][CTL_OE] |=> shared_output_pin == $past(out_now[1]);
  endproperty
  a_pin_prio: assert property (p_pin_prio) else $error("second comparator lost the pin");

  property p_pin_drive;
    @(posedge clk) disable iff (!rstn) (!ctl_r[0][CTL_OE] && !ctl_r[1][CTL_OE]) || pin_dir |=> shared_output_pin_oe_n;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin driven without conditions");

  property p_mirror_read;
    @(posedge clk) disable iff (!rstn) (rd && addr == OFS_AUX) |=> $stable(latch_rd_r);
  endproperty
  a_mirror_read: assert property (p_mirror_read) else $error("mirror read changed read latch");

  property p_rd_capture_two;
    @(posedge clk) disable iff (!rstn) (rd && addr == OFS_CTL_TWO) |=> latch_rd_r[1] == $past(latch_smp_r[1]);
  endproperty
  a_rd_capture_two: assert property (p_rd_capture_two) else $error("second read latch missed capture");

  property p_rd_clears;
    @(posedge clk) disable iff (!rstn) (rd && addr == OFS_CTL_ONE && !q1_r) |=> !mism[0];
  endproperty
  a_rd_clears: assert property (p_rd_clears) else $error("read did not clear mismatch");

  property p_wr_clears_one;
    @(posedge clk) disable iff (!rstn) (wr && addr == OFS_CTL_ONE && !q1_r) |=> !mism[0];
  endproperty
  a_wr_clears_one: assert property (p_wr_clears_one) else $error("write did not clear first mismatch");

  property p_flag_hold;
    @(posedge clk) disable iff (!rstn) (irq_r[IRQ_FLAG_LO] && !(wr && addr == OFS_IRQ)) |=> irq_r[IRQ_FLAG_LO];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without software clear");

  property p_sw_clear;
    @(posedge clk) disable iff (!rstn)
      (wr && addr == OFS_IRQ && !wdata[IRQ_FLAG_LO] && !flag_set[0]) |=> !irq_r[IRQ_FLAG_LO];
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("software clear of flag lost");

  property p_no_level_set;
    @(posedge clk) disable iff (!rstn)
      (!irq_r[IRQ_FLAG_LO] && !flag_set[0] && !(wr && addr == OFS_IRQ)) |=> !irq_r[IRQ_FLAG_LO];
  endproperty
  a_no_level_set: assert property (p_no_level_set) else $error("flag set without mismatch edge");

  property p_smp_q1;
    @(posedge clk) disable iff (!rstn) !q1_r |=> $stable(latch_smp_r);
  endproperty
  a_smp_q1: assert property (p_smp_q1) else $error("sample latch moved outside first phase");

  property p_wake_gate;
    @(posedge clk) disable iff (!rstn) !irq_r[IRQ_PERIPHERAL_IRQ_ENABLE] |=> !wake_req;
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake without peripheral enable");

  property p_req_all;
    @(posedge clk) disable iff (!rstn)
      (irq_r[IRQ_FLAG_LO] && irq_r[IRQ_IE_LO] && irq_r[IRQ_PERIPHERAL_IRQ_ENABLE] && irq_r[IRQ_GIE]) |=> irq_req;
  endproperty
  a_req_all: assert property (p_req_all) else $error("request missing with all enables set");

  property p_pin_first;
    @(posedge clk) disable iff (!rstn)
      (!ctl_r[1][CTL_OE] && ctl_r[0][CTL_OE]) |=> shared_output_pin == $past(out_now[0]);
  endproperty
  a_pin_first: assert property (p_pin_first) else $error("first comparator missing on pin");

  property p_off_pol_two;
    @(posedge clk) disable iff (!rstn) !ctl_r[1][CTL_ON] |-> out_now[1] == ctl_r[1][CTL_POL];
  endproperty
  a_off_pol_two: assert property (p_off_pol_two) else $error("second disabled output not polarity");

endmodule : cmpc_top

// *** sim/cmpc_analog_model.sv ***
// Behavioural model of the two analog comparator cores behind the control block.
// Assumes the bench drives input levels as small unsigned codes; result changes just after a clock edge.
`timescale 1ns/10ps
module cmpc_analog_model (
  input  wire logic        clk,
  input  wire logic [1:0]  cmp_enable,
  input  wire logic [1:0]  reference_select,
  input  wire logic [3:0]  inverting_channel_select,
  input  wire logic [7:0]  pos_lvl,
  input  wire logic [7:0]  ref_lvl,
  input  wire logic [15:0] neg_lvl,
  output logic      [1:0]  cmp_raw
);
  logic [3:0] vp [2];
  logic [3:0] vn [2];
  logic [1:0] ch [2];
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      ch[i] = inverting_channel_select[2*i+:2];
      vp[i] = reference_select[i] ? ref_lvl[4*i+:4] : pos_lvl[4*i+:4];
      vn[i] = (ch[i] == 2'h0) ? 4'h0 : neg_lvl[4*ch[i]+:4];
    end
  end
  // Disabled core hands 0 to the polarity gate
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      cmp_raw[i] <= cmp_enable[i] & (vp[i] > vn[i]);
    end
  end
endmodule : cmpc_analog_model

// *** sim/cmpc_top_tb.sv ***
// Self-checking bench for the dual comparator control block with an analog core model.
// Assumes the package register map and one-cycle read latency of the register port.
`timescale 1ns/10ps
module cmpc_top_tb;
  import cmpc_pkg::*;
  logic              clk, rstn, wr, rd, sleep_mode, pin_dir, port_latch;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, c;
  logic [1:0]        cmp_raw, cmp_enable, sps, rsel, rsrc, hys;
  logic [3:0]        ics;
  logic              pin, pin_oe_n, irq_req, wake_req;
  logic [7:0]        pos_lvl, ref_lvl;
  logic [15:0]       neg_lvl;
  int                fail_count, n_tests;
  // Rows: address, write data, expected read back
  logic [19:0]       rows [5] = '{20'h01f5f, 20'h10303, 20'h2ffbf, 20'h33c3c, 20'h7ff00};

  cmpc_top dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cmp_raw(cmp_raw), .sleep_mode(sleep_mode), .pin_dir(pin_dir), .port_latch(port_latch),
    .cmp_enable(cmp_enable), .speed_power_select(sps), .reference_select(rsel),
    .inverting_channel_select(ics), .reference_source_select(rsrc), .hysteresis_enable(hys),
    .shared_output_pin(pin), .shared_output_pin_oe_n(pin_oe_n), .irq_req(irq_req), .wake_req(wake_req));
  cmpc_analog_model model (.clk(clk), .cmp_enable(cmp_enable), .reference_select(rsel),
    .inverting_channel_select(ics), .pos_lvl(pos_lvl), .ref_lvl(ref_lvl), .neg_lvl(neg_lvl),
    .cmp_raw(cmp_raw));

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  task wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 check(rdata, e);
  endtask : rd_reg
  task automatic wait_irq(input int n);
    int k;
    k = 0;
    while (irq_req !== 1'b1 && k < n) begin
      @(posedge clk);
      #1 k++;
    end
    n_tests++;
    if (irq_req !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: interrupt request missing", $time);
      tally_and_finish();
    end
  endtask : wait_irq

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {rstn, wr, rd, sleep_mode, pin_dir, port_latch, addr, wdata} = '0;
    {pos_lvl, ref_lvl, neg_lvl, fail_count, n_tests} = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr_reg(rows[i][19:16], rows[i][15:8]);
      idle(5);
      rd_reg(rows[i][19:16], rows[i][7:0]);
    end
    check({sps, rsel, ics}, 8'h5f);
    check({rsrc, hys, 4'h0}, 8'hf0);
    @(posedge clk) rstn <= 1'b0;
    idle(2);
    @(posedge clk) rstn <= 1'b1;
    #1 check({cmp_enable, sps, pin_oe_n, irq_req, wake_req, 1'b0}, 8'h38);
    for (int i = 0; i < 4; i++) rd_reg(4'(i), (i < 2) ? CTL_RST : 8'h00);
    wr_reg(OFS_CTL_ONE, 8'h80);
    idle(25);
    wr_reg(OFS_IRQ, 8'h3c);
    @(posedge clk) pos_lvl <= 8'h05;
    wait_irq(8);
    rd_reg(OFS_IRQ, 8'h3d);
    wr_reg(OFS_IRQ, 8'h3c);
    idle(8);
    rd_reg(OFS_IRQ, 8'h3c);
    rd_reg(OFS_CTL_ONE, 8'hc0);
    @(posedge clk) pos_lvl <= 8'h00;
    wait_irq(8);
    wr_reg(OFS_IRQ, 8'h3c);
    rd_reg(OFS_AUX, 8'h00);
    @(posedge clk) pos_lvl <= 8'h05;
    idle(8);
    check({7'h0, irq_req}, 8'h00);
    @(posedge clk) pos_lvl <= 8'h00;
    wait_irq(8);
    wr_reg(OFS_IRQ, 8'h3c);
    sleep_mode <= 1'b1;
    wr_reg(OFS_CTL_ONE, 8'h80);
    @(posedge clk) pos_lvl <= 8'h05;
    wait_irq(5);
    wr_reg(OFS_IRQ, 8'h1d);
    idle(2);
    check({6'h0, irq_req, wake_req}, 8'h01);
    @(posedge clk) sleep_mode <= 1'b0;
    wr_reg(OFS_IRQ, 8'h3e);
    idle(2);
    check({7'h0, irq_req}, 8'h01);
    wr_reg(OFS_IRQ, 8'h00);
    wr_reg(OFS_CTL_ONE, 8'h90);
    idle(6);
    rd_reg(OFS_CTL_ONE, 8'h90);
    @(posedge clk) neg_lvl <= 16'h3640;
    ref_lvl <= 8'h09;
    for (int i = 0; i < 5; i++) begin
      c = (i < 4) ? (8'h80 | 8'(i)) : 8'h86;
      wr_reg(OFS_CTL_ONE, c);
      idle(6);
      rd_reg(OFS_CTL_ONE, (i == 2) ? c : (c | 8'h40));
    end
    for (int k = 0; k < 4; k++) begin
      wr_reg(OFS_CTL_ONE, k[0] ? 8'ha0 : 8'h80);
      wr_reg(OFS_CTL_TWO, k[1] ? 8'ha0 : 8'h80);
      idle(6);
      check({7'h0, pin}, (k == 1) ? 8'h01 : 8'h00);
      if (k > 0) check({7'h0, pin_oe_n}, 8'h00);
    end
    @(posedge clk) pin_dir <= 1'b1;
    idle(3);
    check({7'h0, pin_oe_n}, 8'h01);
    tally_and_finish();
  end
endmodule : cmpc_top_tb
